// *** rtl/cmp_pkg.sv ***
// Constants shared by the analog threshold comparator
package cmp_pkg;
  localparam int unsigned CLOCK_NS       = 100;      // 10 MHz system clock
  localparam int unsigned TICK_NS        = 1000000;  // Evaluation tick, 1 ms
  localparam int unsigned TICK_CYCLES    = TICK_NS / CLOCK_NS;
  localparam int unsigned TICKS_PER_SEC  = 1000;
  localparam int unsigned VAL_W          = 32;
  localparam int unsigned SEL_W          = 5;
  localparam int unsigned DLY_W          = 16;
  localparam logic [DLY_W-1:0] DLY_MAX   = 16'h8ca0;  // 36000 s
  localparam logic [DLY_W-1:0] DLY_RST   = 16'h0000;  // 0 s
  localparam logic [9:0] TPS_LAST        = 10'h3e7;   // TICKS_PER_SEC - 1
  // Configuration reset values, highest legal selector code and select encodings
  localparam logic signed [VAL_W-1:0] UPPER_RST = 32'sh0000012c;  // 300 rpm
  localparam logic signed [VAL_W-1:0] LOWER_RST = 32'sh000000c8;  // 200 rpm
  localparam logic [SEL_W-1:0] SEL_RST   = 5'h01;     // Speed
  localparam logic [SEL_W-1:0] SEL_LAST  = 5'h1a;     // Highest legal code, 26
  localparam logic STYLE_HYST            = 1'b0;
  localparam logic STYLE_WINDOW          = 1'b1;
  localparam logic SIGN_ABS              = 1'b0;
  localparam logic SIGN_SIGNED           = 1'b1;
  // Quantity select codes with a range of their own, fixed except speed, which follows max_speed
  localparam logic [SEL_W-1:0] Q_SPEED   = 5'h01;
  localparam logic [SEL_W-1:0] Q_OUTVOLT = 5'h06;
  localparam logic [SEL_W-1:0] Q_FREQ    = 5'h07;
  localparam logic [SEL_W-1:0] Q_DCVOLT  = 5'h08;
  localparam logic [SEL_W-1:0] Q_IGBT    = 5'h09;
  localparam logic [SEL_W-1:0] Q_PT1     = 5'h0a;
  localparam logic [SEL_W-1:0] Q_PT3     = 5'h0c;
  localparam logic [SEL_W-1:0] Q_ENERGY  = 5'h0d;
  localparam logic [SEL_W-1:0] Q_RUNH    = 5'h0e;
  localparam logic [SEL_W-1:0] Q_MAINSH  = 5'h0f;
  localparam logic [SEL_W-1:0] Q_AIN1    = 5'h10;
  localparam logic [SEL_W-1:0] Q_AIN4    = 5'h13;
  localparam logic [SEL_W-1:0] Q_PT4     = 5'h16;
  localparam logic [SEL_W-1:0] Q_PT6     = 5'h18;
  localparam logic [SEL_W-1:0] Q_MUX1    = 5'h19;
  localparam logic [SEL_W-1:0] Q_MUX2    = 5'h1a;
  // Range limits, raw integer units
  localparam logic signed [VAL_W-1:0] MAX_OUTVOLT = 32'sh000003e8;  // 1000
  localparam logic signed [VAL_W-1:0] MAX_FREQ    = 32'sh00000190;  // 400
  localparam logic signed [VAL_W-1:0] MAX_DCVOLT  = 32'sh000004e2;  // 1250
  localparam logic signed [VAL_W-1:0] MAX_IGBT    = 32'sh00000064;  // 100
  localparam logic signed [VAL_W-1:0] MAX_PT      = 32'sh0000012c;  // 300
  localparam logic signed [VAL_W-1:0] MIN_PT      = -32'sh00000064; // -100
  localparam logic signed [VAL_W-1:0] MAX_ENERGY  = 32'sh000f4240;  // 1000000
  localparam logic signed [VAL_W-1:0] MAX_HOURS   = 32'sh0000ffff;  // 65535
  localparam logic signed [VAL_W-1:0] MAX_PCT     = 32'sh00000064;  // 100
  localparam logic signed [VAL_W-1:0] ZERO        = 32'sh00000000;
  // Output delay states, one-hot
  typedef enum logic [2:0] {
    DLY_IDLE  = 3'b001,
    DLY_SET   = 3'b010,
    DLY_CLEAR = 3'b100
  } dly_state_t;
endpackage

// *** rtl/analog_compare_unit_one.sv ***
// Analog threshold comparator unit with hysteresis/window modes and output delays
`timescale 1ns/1ps
//
// Contract
// - Upper threshold held, reset value 300, in the selected quantity's unit.
// - Lower threshold held, reset value 200, same unit and range as upper.
// - Threshold range follows quantity: speed to max, 400, 1250, 65535 and others.
// - Style select: 0 hysteresis, 1 window; hysteresis after reset.
// - Sign select: 0 absolute value, 1 signed value; absolute after reset.
// - With signed compare, lowest threshold becomes minus the quantity maximum.
// - Hysteresis: output goes high when value rises past upper threshold.
// - Hysteresis: output goes low when value falls past lower threshold.
// - Hysteresis: between thresholds the output keeps its state.
// - Window: output high while value lies between lower and upper.
// - Window: output low whenever value is below lower or above upper.
// - Output assertion delayed by assert delay, 0 to 36000 s, default 0.
// - Output deassertion delayed by deassert delay, 0 to 36000 s, default 0.
// - Running delay timer count readable in seconds, 0 to 36000.
// - Hysteresis with lower above upper latches the output once set.
// - Quantity selector code 0 to 26, speed code 1 after reset.
module analog_compare_unit_one
  import cmp_pkg::*;
#(
  parameter int unsigned TICK_DIV = cmp_pkg::TICK_CYCLES
) (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire logic                              cfg_write,
  input  wire logic signed [cmp_pkg::VAL_W-1:0]  cfg_upper_threshold,
  input  wire logic signed [cmp_pkg::VAL_W-1:0]  cfg_lower_threshold,
  input  wire logic                              cfg_compare_style_select,
  input  wire logic                              cfg_sign_handling_select,
  input  wire logic        [cmp_pkg::DLY_W-1:0]  cfg_assert_delay,
  input  wire logic        [cmp_pkg::DLY_W-1:0]  cfg_deassert_delay,
  input  wire logic        [cmp_pkg::SEL_W-1:0]  cfg_monitored_quantity_select,
  input  wire logic signed [cmp_pkg::VAL_W-1:0]  max_speed,
  input  wire logic signed [cmp_pkg::VAL_W-1:0]  quantity_max,
  input  wire logic signed [cmp_pkg::VAL_W-1:0]  monitored_value,
  output logic signed      [cmp_pkg::VAL_W-1:0]  upper_threshold,
  output logic signed      [cmp_pkg::VAL_W-1:0]  lower_threshold,
  output logic                                   compare_style_select,
  output logic                                   sign_handling_select,
  output logic             [cmp_pkg::DLY_W-1:0]  assert_delay,
  output logic             [cmp_pkg::DLY_W-1:0]  deassert_delay,
  output logic             [cmp_pkg::SEL_W-1:0]  monitored_quantity_select,
  output logic             [cmp_pkg::DLY_W-1:0]  delay_timer_count,
  output logic                                   eval_tick,
  output logic                                   raw_compare,
  output logic                                   compare_out
);
  import cmp_pkg::*;

  logic signed [VAL_W-1:0] upper_r, lower_r;
  logic                    style_r, sign_r;
  logic        [DLY_W-1:0] set_dly_r, clr_dly_r;
  logic        [SEL_W-1:0] sel_r;
  logic        [13:0]      div_r;
  logic        [9:0]       sub_r;
  logic        [DLY_W-1:0] timer_r, timer_nxt;
  logic        [9:0]       sub_nxt;
  logic                    raw_r, raw_nxt, out_r, out_nxt;
  dly_state_t              state_r, state_nxt;

  // Range of the quantity that the new configuration selects
  logic signed [VAL_W-1:0] rng_max, rng_min_abs, rng_min;
  always_comb begin
    rng_max     = quantity_max;  // Process and power-type quantities come from outside
    rng_min_abs = ZERO;
    if (cfg_monitored_quantity_select == Q_SPEED) begin
      rng_max = max_speed;
    end else if (cfg_monitored_quantity_select == Q_OUTVOLT) begin
      rng_max = MAX_OUTVOLT;
    end else if (cfg_monitored_quantity_select == Q_FREQ) begin
      rng_max = MAX_FREQ;
    end else if (cfg_monitored_quantity_select == Q_DCVOLT) begin
      rng_max = MAX_DCVOLT;
    end else if (cfg_monitored_quantity_select == Q_IGBT) begin
      rng_max = MAX_IGBT;
    end else if ((cfg_monitored_quantity_select >= Q_PT1 &&
                  cfg_monitored_quantity_select <= Q_PT3) ||
                 (cfg_monitored_quantity_select >= Q_PT4 &&
                  cfg_monitored_quantity_select <= Q_PT6)) begin
      rng_max     = MAX_PT;
      rng_min_abs = MIN_PT;
    end else if (cfg_monitored_quantity_select == Q_ENERGY) begin
      rng_max = MAX_ENERGY;
    end else if (cfg_monitored_quantity_select == Q_RUNH ||
                 cfg_monitored_quantity_select == Q_MAINSH) begin
      rng_max = MAX_HOURS;
    end else if ((cfg_monitored_quantity_select >= Q_AIN1 &&
                  cfg_monitored_quantity_select <= Q_AIN4) ||
                 cfg_monitored_quantity_select == Q_MUX1 ||
                 cfg_monitored_quantity_select == Q_MUX2) begin
      rng_max = MAX_PCT;
    end
  end
  assign rng_min = (cfg_sign_handling_select == SIGN_SIGNED) ? -rng_max : rng_min_abs;

  // Clamp requested values so stored thresholds never leave the legal range
  wire signed [VAL_W-1:0] upper_clamp = (cfg_upper_threshold > rng_max) ? rng_max :
                                        (cfg_upper_threshold < rng_min) ? rng_min :
                                        cfg_upper_threshold;
  wire signed [VAL_W-1:0] lower_clamp = (cfg_lower_threshold > rng_max) ? rng_max :
                                        (cfg_lower_threshold < rng_min) ? rng_min :
                                        cfg_lower_threshold;
  wire        [DLY_W-1:0] set_clamp   = (cfg_assert_delay > DLY_MAX) ? DLY_MAX :
                                        cfg_assert_delay;
  wire        [DLY_W-1:0] clr_clamp   = (cfg_deassert_delay > DLY_MAX) ? DLY_MAX :
                                        cfg_deassert_delay;
  wire        [SEL_W-1:0] sel_clamp   = (cfg_monitored_quantity_select > SEL_LAST) ?
                                        sel_r : cfg_monitored_quantity_select;  // Illegal code ignored

  // Configuration store, loaded as one atomic write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upper_r   <= UPPER_RST;
      lower_r   <= LOWER_RST;
      style_r   <= STYLE_HYST;
      sign_r    <= SIGN_ABS;
      set_dly_r <= DLY_RST;
      clr_dly_r <= DLY_RST;
      sel_r     <= SEL_RST;
    end else if (cfg_write) begin
      upper_r   <= upper_clamp;
      lower_r   <= lower_clamp;
      style_r   <= cfg_compare_style_select;
      sign_r    <= cfg_sign_handling_select;
      set_dly_r <= set_clamp;
      clr_dly_r <= clr_clamp;
      sel_r     <= sel_clamp;
    end
  end

  // Evaluation tick divider; the tick paces both compare and delay timing
  wire tick = (div_r == 14'(TICK_DIV - 1));
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 14'h0000;
    end else begin
      div_r <= tick ? 14'h0000 : div_r + 14'h0001;
    end
  end

  // Value as compared: magnitude unless signed handling is chosen
  wire signed [VAL_W-1:0] cmp_val = (sign_r == SIGN_SIGNED || !monitored_value[VAL_W-1]) ?
                                    monitored_value : -monitored_value;
  wire above_upper  = cmp_val > upper_r;
  wire below_lower  = cmp_val < lower_r;
  wire inside_band  = (cmp_val >= lower_r) && (cmp_val <= upper_r);
  // Lower above upper disables the reset path, so a set output latches
  wire latch_mode   = lower_r > upper_r;

  // Raw comparator decision
  always_comb begin
    raw_nxt = raw_r;
    if (style_r == STYLE_WINDOW) begin
      raw_nxt = inside_band;
    end else if (above_upper) begin
      raw_nxt = 1'b1;
    end else if (below_lower && !latch_mode) begin
      raw_nxt = 1'b0;
    end                                         // Otherwise hold
  end

  // Delay shaping: timer counts seconds while raw differs from output
  always_comb begin
    state_nxt = DLY_IDLE;
    timer_nxt = 16'h0000;
    sub_nxt   = 10'h000;
    out_nxt   = out_r;
    if (raw_nxt != out_r) begin
      state_nxt = raw_nxt ? DLY_SET : DLY_CLEAR;
      if (state_r != state_nxt) begin
        timer_nxt = 16'h0000;                   // Fresh start of a delay
        sub_nxt   = 10'h000;
      end else begin
        timer_nxt = timer_r;
        sub_nxt   = sub_r;
      end
      if (timer_nxt >= (raw_nxt ? set_dly_r : clr_dly_r)) begin
        out_nxt   = raw_nxt;
        state_nxt = DLY_IDLE;
        timer_nxt = 16'h0000;
        sub_nxt   = 10'h000;
      end else if (sub_nxt == TPS_LAST) begin
        sub_nxt   = 10'h000;
        timer_nxt = timer_nxt + 16'h0001;       // Whole seconds
      end else begin
        sub_nxt   = sub_nxt + 10'h001;
      end
    end                                          // Match cancels the delay
  end

  // Comparator and delay state advance only on the tick
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      raw_r   <= 1'b0;
      out_r   <= 1'b0;
      timer_r <= 16'h0000;
      sub_r   <= 10'h000;
      state_r <= DLY_IDLE;
    end else if (tick) begin
      raw_r   <= raw_nxt;
      out_r   <= out_nxt;
      timer_r <= timer_nxt;
      sub_r   <= sub_nxt;
      state_r <= state_nxt;
    end
  end

  // Output drive, all from flip-flops except the tick strobe
  assign upper_threshold           = upper_r;
  assign lower_threshold           = lower_r;
  assign compare_style_select      = style_r;
  assign sign_handling_select      = sign_r;
  assign assert_delay              = set_dly_r;
  assign deassert_delay            = clr_dly_r;
  assign monitored_quantity_select = sel_r;
  assign delay_timer_count         = timer_r;
  assign eval_tick                 = tick;
  assign raw_compare               = raw_r;
  assign compare_out               = out_r;

  // Checks
  AST_UPPER_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write |=> (upper_r <= $past(rng_max)) && (lower_r <= $past(rng_max)))
    else $error("Threshold stored above quantity maximum");
  AST_SIGNED_MIN: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write && cfg_sign_handling_select && (cfg_lower_threshold < rng_min)
    |=> lower_r == $past(rng_min))
    else $error("Signed lower limit not minus maximum");
  AST_HYST_SET: assert property (@(posedge clock) disable iff (!rst_b)
    tick && style_r == STYLE_HYST && above_upper |=> raw_r)
    else $error("Hysteresis did not set above upper");
  AST_HYST_CLR: assert property (@(posedge clock) disable iff (!rst_b)
    tick && style_r == STYLE_HYST && below_lower && !above_upper && !latch_mode |=> !raw_r)
    else $error("Hysteresis did not clear below lower");
  AST_HYST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    tick && style_r == STYLE_HYST && !above_upper && !below_lower |=> $stable(raw_r))
    else $error("Hysteresis changed between thresholds");
  AST_WIN_IN: assert property (@(posedge clock) disable iff (!rst_b)
    tick && style_r == STYLE_WINDOW && cmp_val >= lower_r && cmp_val <= upper_r |=> raw_r)
    else $error("Window not high inside band");
  AST_WIN_OUT: assert property (@(posedge clock) disable iff (!rst_b)
    tick && style_r == STYLE_WINDOW && (cmp_val < lower_r || cmp_val > upper_r) |=> !raw_r)
    else $error("Window not low outside band");
  AST_LATCH: assert property (@(posedge clock) disable iff (!rst_b)
    style_r == STYLE_HYST && latch_mode && raw_r && !cfg_write |=> raw_r)
    else $error("Latched output released");
  AST_TIMER_MAX: assert property (@(posedge clock) disable iff (!rst_b)
    timer_r <= DLY_MAX)
    else $error("Delay timer beyond limit");
  AST_CANCEL: assert property (@(posedge clock) disable iff (!rst_b)
    tick && raw_nxt == out_r |=> timer_r == 16'h0000 && state_r == DLY_IDLE)
    else $error("Delay not cancelled on match");
  AST_OUT_TICK: assert property (@(posedge clock) disable iff (!rst_b)
    !tick |=> $stable(out_r) && $stable(raw_r))
    else $error("Output moved off tick");
  AST_SET_DELAY: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(out_r) |-> $past(timer_r) >= $past(set_dly_r))
    else $error("Output set before delay");
  AST_CLR_DELAY: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(out_r) |-> $past(timer_r) >= $past(clr_dly_r))
    else $error("Output cleared before delay");

  // Configuration store checks; a negative maximum input would void the range ones
  AST_LOWER_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write |=> (upper_r >= $past(rng_min)) && (lower_r >= $past(rng_min)))
    else $error("Threshold stored below quantity minimum");
  AST_DLY_CLAMP: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write |=> (set_dly_r <= DLY_MAX) && (clr_dly_r <= DLY_MAX))
    else $error("Delay stored beyond limit");
  AST_STYLE_LOAD: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write |=> (style_r == $past(cfg_compare_style_select)) &&
                  (sign_r == $past(cfg_sign_handling_select)))
    else $error("Style or sign select not loaded");
  AST_SEL_LOAD: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write && (cfg_monitored_quantity_select <= SEL_LAST)
    |=> sel_r == $past(cfg_monitored_quantity_select))
    else $error("Legal selector code not stored");
  AST_SEL_KEEP: assert property (@(posedge clock) disable iff (!rst_b)
    cfg_write && (cfg_monitored_quantity_select > SEL_LAST) |=> $stable(sel_r))
    else $error("Illegal selector code was stored");
  // Delay timer checks: seconds only step up by one or restart from zero
  AST_TIMER_STEP: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(timer_r) |-> (timer_r == 16'h0000) || (timer_r == $past(timer_r) + 16'h0001))
    else $error("Delay timer skipped a second");
  AST_TIMER_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == DLY_IDLE |-> (timer_r == 16'h0000) && (sub_r == 10'h000))
    else $error("Idle delay state with running timer");
  AST_FIRE_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(out_r) |-> (timer_r == 16'h0000) && (state_r == DLY_IDLE))
    else $error("Timer not cleared when output moved");
  AST_ZERO_SET: assert property (@(posedge clock) disable iff (!rst_b)
    tick && raw_nxt && !out_r && (set_dly_r == DLY_RST) |=> out_r)
    else $error("Zero set delay did not pass through");
  AST_ZERO_CLR: assert property (@(posedge clock) disable iff (!rst_b)
    tick && !raw_nxt && out_r && (clr_dly_r == DLY_RST) |=> !out_r)
    else $error("Zero reset delay did not pass through");

endmodule // analog_compare_unit_one

// *** verif/analog_compare_unit_one_tb.sv ***
// Self-checking bench for the analog threshold comparator unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module analog_compare_unit_one_tb;
  import cmp_pkg::*;
  localparam int unsigned DIV = 4;  // Short tick keeps one second at 4000 clocks
  typedef struct {
    logic [SEL_W-1:0]        sel;
    logic                    sty;
    logic                    sgn;
    logic signed [VAL_W-1:0] up;
    logic signed [VAL_W-1:0] lo;
    logic signed [VAL_W-1:0] val;
    logic signed [VAL_W-1:0] eu;
    logic signed [VAL_W-1:0] el;
    logic                    out;
  } row_t;
  logic clock, rst_b, cfg_write, cfg_sty, cfg_sgn;
  logic signed [VAL_W-1:0] cfg_up, cfg_lo, mval;
  logic signed [VAL_W-1:0] spd_max, q_max;  // Range maxima are live inputs, not ties
  logic [DLY_W-1:0] cfg_ad, cfg_dd, delay_timer_count, assert_delay, deassert_delay;
  logic [SEL_W-1:0] cfg_sel, monitored_quantity_select;
  logic signed [VAL_W-1:0] upper_threshold, lower_threshold;
  logic compare_style_select, sign_handling_select, eval_tick, raw_compare, compare_out;
  int err_count, n_compared, n, peak;
  // Value rows run in order, so hysteresis rows lean on the state left by the row above
  row_t rows [29] = '{
    '{5'h01, 0, 0, 300, 200, 250, 300, 200, 0}, '{5'h01, 0, 0, 300, 200, 350, 300, 200, 1},
    '{5'h01, 0, 0, 300, 200, 250, 300, 200, 1}, '{5'h01, 0, 0, 300, 200, 150, 300, 200, 0},
    '{5'h01, 0, 0, 300, 200, -350, 300, 200, 1}, '{5'h01, 0, 1, 300, -200, -350, 300, -200, 0},
    '{5'h01, 1, 0, 300, 200, 250, 300, 200, 1}, '{5'h01, 1, 0, 300, 200, 200, 300, 200, 1},
    '{5'h01, 1, 0, 300, 200, 301, 300, 200, 0}, '{5'h01, 1, 0, 300, 200, 199, 300, 200, 0},
    '{5'h01, 1, 0, 300, 200, -250, 300, 200, 1}, '{5'h01, 1, 1, 300, 200, -250, 300, 200, 0},
    '{5'h07, 1, 0, 500, -5, 0, 400, 0, 1}, '{5'h08, 1, 1, 2000, -2000, 0, 1250, -1250, 1},
    '{5'h0e, 0, 0, 70000, 10, 5, 65535, 10, 0}, '{5'h01, 0, 0, 2000, 0, 1600, 1500, 0, 1},
    '{5'h01, 0, 0, 300, 200, 100, 300, 200, 0}, '{5'h01, 0, 0, 200, 300, 100, 200, 300, 0},
    '{5'h01, 0, 0, 200, 300, 250, 200, 300, 1}, '{5'h01, 0, 0, 200, 300, 0, 200, 300, 1},
    '{5'h01, 0, 0, 300, 200, 0, 300, 200, 0},
    '{5'h0a, 0, 0, 500, -300, 350, 300, -100, 1}, '{5'h17, 1, 1, 500, -500, -350, 300, -300, 0},
    '{5'h02, 0, 0, 500, 50, 120, 100, 50, 1}, '{5'h09, 1, 0, 150, 10, 50, 100, 10, 1},
    '{5'h0d, 0, 0, 2000000, 5, 3, 1000000, 5, 0}, '{5'h06, 1, 0, 1200, 900, 950, 1000, 900, 1},
    '{5'h19, 1, 0, 300, 40, 60, 100, 40, 1}, '{5'h13, 0, 1, 300, -300, -150, 100, -100, 0}};
  // Selector code beyond the table; thresholds kept inside any range
  row_t odd_row = '{5'h1b, 0, 0, 90, 20, 0, 0, 0, 0};

  analog_compare_unit_one #(.TICK_DIV(DIV)) analog_compare_unit_one_inst (
    .clock(clock), .rst_b(rst_b), .cfg_write(cfg_write),
    .cfg_upper_threshold(cfg_up), .cfg_lower_threshold(cfg_lo),
    .cfg_compare_style_select(cfg_sty), .cfg_sign_handling_select(cfg_sgn),
    .cfg_assert_delay(cfg_ad), .cfg_deassert_delay(cfg_dd),
    .cfg_monitored_quantity_select(cfg_sel), .max_speed(spd_max),
    .quantity_max(q_max), .monitored_value(mval),
    .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
    .compare_style_select(compare_style_select), .sign_handling_select(sign_handling_select),
    .assert_delay(assert_delay), .deassert_delay(deassert_delay),
    .monitored_quantity_select(monitored_quantity_select),
    .delay_timer_count(delay_timer_count), .eval_tick(eval_tick),
    .raw_compare(raw_compare), .compare_out(compare_out));

  // Free-running clock, 100 ns period
  always #50 clock = ~clock;

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle load strobe; all fields travel together
  task automatic write_cfg(input row_t r, input logic [DLY_W-1:0] ad, input logic [DLY_W-1:0] dd);
    cfg_sel = r.sel; cfg_sty = r.sty; cfg_sgn = r.sgn; cfg_up = r.up; cfg_lo = r.lo;
    cfg_ad = ad; cfg_dd = dd; cfg_write = 1'b1;
    @(negedge clock);
    cfg_write = 1'b0;
    @(negedge clock);
  endtask

  // Waits for the next evaluation edge, bounded so a dead divider cannot hang the run
  task automatic wait_tick;
    int i;
    for (i = 0; i < 4 * DIV && eval_tick !== 1'b1; i++) @(negedge clock);
    if (eval_tick !== 1'b1) begin
      err_count++;
      final_report();
    end else @(negedge clock);
  endtask

  // Counts ticks until the delayed output reaches the wanted level
  task automatic ticks_until(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    peak = 0;
    while (compare_out !== lvl && cnt < lim) begin
      wait_tick();
      cnt++;
      if (delay_timer_count > peak) peak = delay_timer_count;
    end
  endtask

  task automatic check_defaults;
    `CHK(upper_threshold, UPPER_RST)
    `CHK(lower_threshold, LOWER_RST)
    `CHK(compare_style_select, STYLE_HYST)
    `CHK(sign_handling_select, SIGN_ABS)
    `CHK(assert_delay, DLY_RST)
    `CHK(deassert_delay, DLY_RST)
    `CHK(delay_timer_count, DLY_RST)
    `CHK(monitored_quantity_select, SEL_RST)
    `CHK(compare_out, 1'b0)
    `CHK(eval_tick, 1'b0)
  endtask

  initial begin
    clock = 1'b0; rst_b = 1'b0; cfg_write = 1'b0; cfg_sty = 1'b0; cfg_sgn = 1'b0;
    cfg_up = '0; cfg_lo = '0; mval = '0; cfg_ad = '0; cfg_dd = '0; cfg_sel = 5'h01;
    err_count = 0; n_compared = 0;
    spd_max = 32'sh000005dc;
    q_max = 32'sh00000064;
    repeat (4) @(negedge clock);
    check_defaults();
    rst_b = 1'b1;
    @(negedge clock);
    // Table of ordinary cases, delays zero so output follows on the same tick
    foreach (rows[i]) begin
      write_cfg(rows[i], 16'h0000, 16'h0000);
      `CHK(upper_threshold, rows[i].eu)
      `CHK(lower_threshold, rows[i].el)
      `CHK(compare_style_select, rows[i].sty)
      `CHK(sign_handling_select, rows[i].sgn)
      `CHK(monitored_quantity_select, rows[i].sel)
      mval = rows[i].val;
      wait_tick();
      `CHK(raw_compare, rows[i].out)
      `CHK(compare_out, rows[i].out)
    end
    // Speed range follows the live maximum; delays clamp; an illegal code keeps the selector
    mval = '0;
    spd_max = 32'sh000003e8;
    write_cfg(rows[15], 16'hffff, 16'h9000);
    `CHK(upper_threshold, 32'sh000003e8)
    `CHK(assert_delay, DLY_MAX)
    `CHK(deassert_delay, DLY_MAX)
    write_cfg(odd_row, 16'h0000, 16'h0000);
    `CHK(monitored_quantity_select, 5'h01)
    `CHK(upper_threshold, 32'sh0000005a)
    `CHK(lower_threshold, 32'sh00000014)
    // One-second set delay: output must hold off for a full second of ticks
    write_cfg(rows[0], 16'h0001, 16'h0001);
    `CHK(assert_delay, 16'h0001)
    `CHK(deassert_delay, 16'h0001)
    mval = 350;
    ticks_until(1'b1, 1100, n);
    `CHK(n >= 1000 && n <= 1001, 1'b1)
    `CHK(peak >= 1, 1'b1)
    `CHK(raw_compare, 1'b1)
    // A return of the raw result after a whole second must drop the pending reset delay
    mval = 150;
    repeat (1000) wait_tick();
    `CHK(compare_out, 1'b1)
    `CHK(delay_timer_count, 16'h0001)
    mval = 350;
    repeat (2) wait_tick();
    `CHK(delay_timer_count, 16'h0000)
    mval = 150;
    ticks_until(1'b0, 1100, n);
    `CHK(n >= 1000 && n <= 1001, 1'b1)
    // Reset in mid-run, with a set delay pending, brings back every default
    mval = 350;
    repeat (2) wait_tick();
    `CHK(raw_compare, 1'b1)
    `CHK(compare_out, 1'b0)
    rst_b = 1'b0;
    @(negedge clock);
    check_defaults();
    `CHK(raw_compare, 1'b0)
    rst_b = 1'b1;
    @(negedge clock);
    `CHK(eval_tick, 1'b0)
    `CHK(compare_out, 1'b0)
    repeat (2) @(negedge clock);
    `CHK(eval_tick, 1'b1)
    // Default delays are zero, so the first tick sets the output at once
    wait_tick();
    `CHK(raw_compare, 1'b1)
    `CHK(compare_out, 1'b1)
    final_report();
  end
endmodule  // analog_compare_unit_one_tb
